/* rtl/pwm_chop_pkg.sv */
// Constants, field layout and types of the current chopping controller.
// Assumes one 125 MHz clock; times below are in nanoseconds.
package pwm_chop_pkg;

  localparam int          CLK_MHZ       = 125;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_SCALE    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam int          DECAY_LSB     = 0;
  localparam int          OFF_TIME_SELECT_LSB      = 4;
  localparam int          BLANK_LSB     = 6;
  localparam int          RIPPLE_LSB    = 8;
  localparam int          VREF_INT_BIT  = 12;
  localparam int          TORQUE_LSB    = 0;
  localparam int          STANDSTILL_LSB = 8;
  localparam logic [2:0]  DECAY_RST     = 3'h7;
  localparam logic [1:0]  OFF_TIME_SELECT_RST      = 2'h1;
  localparam logic [1:0]  BLANK_RST     = 2'h1;
  localparam logic [1:0]  RIPPLE_RST    = 2'h0;
  localparam logic [7:0]  TORQUE_RST    = 8'hFF;
  localparam logic [7:0]  STANDSTILL_RST = 8'h80;

  // ****************************************
  // Decay codes and pin levels
  // ****************************************
  localparam logic [2:0]  DECAY_SLOW    = 3'h0;
  localparam logic [2:0]  DECAY_MIX30   = 3'h4;
  localparam logic [2:0]  DECAY_MIX60   = 3'h5;
  localparam logic [2:0]  DECAY_DYN     = 3'h6;
  localparam logic [2:0]  DECAY_RIPPLE  = 3'h7;
  localparam logic [1:0]  PIN_LOW       = 2'h0;
  localparam logic [1:0]  PIN_HIGH      = 2'h1;
  localparam logic [1:0]  PIN_HIZ       = 2'h2;

  // ****************************************
  // Times and derived cycle counts
  // ****************************************
  localparam int          OFF0_NS       = 9000;
  localparam int          OFF1_NS       = 19000;
  localparam int          OFF2_NS       = 27000;
  localparam int          OFF3_NS       = 35000;
  localparam int          BLANK0_NS     = 1000;
  localparam int          BLANK1_NS     = 1500;
  localparam int          BLANK2_NS     = 2000;
  localparam int          BLANK3_NS     = 2500;
  localparam int          DEGLITCH_NS   = 500;
  localparam int          OFF0_CYC      = (OFF0_NS * CLK_MHZ + 999) / 1000;
  localparam int          OFF1_CYC      = (OFF1_NS * CLK_MHZ + 999) / 1000;
  localparam int          OFF2_CYC      = (OFF2_NS * CLK_MHZ + 999) / 1000;
  localparam int          OFF3_CYC      = (OFF3_NS * CLK_MHZ + 999) / 1000;
  localparam int          BLANK0_CYC    = (BLANK0_NS * CLK_MHZ + 999) / 1000;
  localparam int          BLANK1_CYC    = (BLANK1_NS * CLK_MHZ + 999) / 1000;
  localparam int          BLANK2_CYC    = (BLANK2_NS * CLK_MHZ + 999) / 1000;
  localparam int          BLANK3_CYC    = (BLANK3_NS * CLK_MHZ + 999) / 1000;
  localparam int          DEGLITCH_CYC  = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Reference, ripple and adaptive decay
  // ****************************************
  localparam logic [11:0] VREF_INT_MV   = 12'hCE4;
  localparam logic [2:0]  RIPPLE_PCT0   = 3'h1;
  localparam logic [2:0]  RIPPLE_PCT1   = 3'h2;
  localparam logic [2:0]  RIPPLE_PCT2   = 3'h4;
  localparam logic [2:0]  RIPPLE_PCT3   = 3'h6;
  localparam logic [3:0]  FRAC_MAX      = 4'h8;
  localparam logic [3:0]  FRAC_RST      = 4'h4;

  typedef enum logic [1:0] {ST_DRIVE, ST_FAST, ST_FAST_OFF, ST_SLOW} chop_state_type;

  typedef struct packed {
    logic hs1;
    logic ls1;
    logic hs2;
    logic ls2;
  } gate_type;

  typedef struct packed {
    logic trip;
    logic valley;
    logic near_zero;
    logic falling_step;
  } sense_type;

endpackage

/* rtl/pwm_chop_ctrl.sv */
// Current chopping controller for two H-bridges, with an AHB-Lite register slave.
// Assumes sense flags arrive synchronous to hclk; analog side turns levels into comparators.

// Function
// - Internal enable selects fixed 3.3 V reference; pin configuration always uses the external one
// - Trip and hold levels scale with scalers; pin configuration runs at full scale
// - Drive until chopping threshold is detected
// - Fast decay reverses, then disables near zero
// - Slow decay turns on both low sides
// - Decay code map, ripple control default
// - Reserved decay codes and pin pair unused
// - Decay scheme may change while running
// - Slow decay extends while still above trip
// - Mixed decay: 30 or 60 percent fast
// - Dynamic decay: overshoot raises fast fraction
// - Dynamic decay: long drive lowers fraction
// - Dynamic decay: falling step uses full fast
// - Ripple control: slow decay until valley
// - Valley is 25 mV plus ripple percent
// - Off time 9, 19, 27, 35 us
// - Off time may change while running
// - Blanking ignores comparator after drive start
// - Pin configuration fixes blanking at 1.5 us
// - Blanking field selects 1 to 2.5 us
// - Trip must persist 0.5 us deglitch
// - Off time expiry restarts the drive phase
// - Standstill scaler sets the holding current
module pwm_chop_ctrl #(
  parameter int          OFF0_CYC       = pwm_chop_pkg::OFF0_CYC,
  parameter int          OFF1_CYC       = pwm_chop_pkg::OFF1_CYC,
  parameter int          OFF2_CYC       = pwm_chop_pkg::OFF2_CYC,
  parameter int          OFF3_CYC       = pwm_chop_pkg::OFF3_CYC,
  parameter int          LONG_DRIVE_CYC = 1000,
  parameter logic [11:0] RIPPLE_BASE    = 12'h019
) (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          hw_mode,
  input  wire logic [1:0]                    decay_pin_a,
  input  wire logic [1:0]                    decay_pin_b,
  input  wire logic [1:0]                    off_time_pin,
  input  wire logic                          holding,
  input  wire logic [11:0]                   ext_vref_mv,
  input  wire logic [1:0]                    dir,
  input  wire pwm_chop_pkg::sense_type [1:0] sense,
  output pwm_chop_pkg::gate_type [1:0]       gate,
  output logic      [11:0]                   trip_level,
  output logic      [11:0]                   valley_level
);

  // ****************************************
  // Register slave
  // ****************************************
  logic [2:0]  decay_q;
  logic [1:0]  off_time_select_q;
  logic [1:0]  blank_q;
  logic [1:0]  ripple_q;
  logic        vref_int_q;
  logic [7:0]  torque_q;
  logic [7:0]  standstill_q;
  logic        wr_pend_q;
  logic [7:0]  addr_q;
  logic [2:0]  eff_decay_q;
  logic [2:0]  pin_decay;
  logic        pin_valid;
  logic        access;
  logic [31:0] rd_mux;
  logic [3:0]  frac_q [2];
  pwm_chop_pkg::chop_state_type st_q [2];

  assign access = hsel && hready && htrans[1];

  function automatic logic decay_ok(input logic [2:0] code);
    decay_ok = (code == pwm_chop_pkg::DECAY_SLOW) || code[2];
  endfunction

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      pwm_chop_pkg::ADDR_CTRL: begin
        rd_mux[pwm_chop_pkg::DECAY_LSB +: 3]   = decay_q;
        rd_mux[pwm_chop_pkg::OFF_TIME_SELECT_LSB +: 2]    = off_time_select_q;
        rd_mux[pwm_chop_pkg::BLANK_LSB +: 2]   = blank_q;
        rd_mux[pwm_chop_pkg::RIPPLE_LSB +: 2]  = ripple_q;
        rd_mux[pwm_chop_pkg::VREF_INT_BIT]     = vref_int_q;
      end
      pwm_chop_pkg::ADDR_SCALE: begin
        rd_mux[pwm_chop_pkg::TORQUE_LSB +: 8]     = torque_q;
        rd_mux[pwm_chop_pkg::STANDSTILL_LSB +: 8] = standstill_q;
      end
      pwm_chop_pkg::ADDR_STATUS: begin
        rd_mux[15:0] = {frac_q[1], frac_q[0], 1'b0, eff_decay_q, st_q[1], st_q[0]};
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= access && hwrite;
      if (access) begin
        addr_q <= haddr[7:0];
      end
      if (access && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Writes land in the data phase; a reserved decay code leaves the old scheme running.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      decay_q      <= pwm_chop_pkg::DECAY_RST;
      off_time_select_q       <= pwm_chop_pkg::OFF_TIME_SELECT_RST;
      blank_q      <= pwm_chop_pkg::BLANK_RST;
      ripple_q     <= pwm_chop_pkg::RIPPLE_RST;
      vref_int_q   <= 1'b0;
      torque_q     <= pwm_chop_pkg::TORQUE_RST;
      standstill_q <= pwm_chop_pkg::STANDSTILL_RST;
    end else if (wr_pend_q) begin
      if (addr_q == pwm_chop_pkg::ADDR_CTRL) begin
        if (decay_ok(hwdata[pwm_chop_pkg::DECAY_LSB +: 3])) begin
          decay_q <= hwdata[pwm_chop_pkg::DECAY_LSB +: 3];
        end
        off_time_select_q     <= hwdata[pwm_chop_pkg::OFF_TIME_SELECT_LSB +: 2];
        blank_q    <= hwdata[pwm_chop_pkg::BLANK_LSB +: 2];
        ripple_q   <= hwdata[pwm_chop_pkg::RIPPLE_LSB +: 2];
        vref_int_q <= hwdata[pwm_chop_pkg::VREF_INT_BIT];
      end
      if (addr_q == pwm_chop_pkg::ADDR_SCALE) begin
        torque_q     <= hwdata[pwm_chop_pkg::TORQUE_LSB +: 8];
        standstill_q <= hwdata[pwm_chop_pkg::STANDSTILL_LSB +: 8];
      end
    end
  end

  // ****************************************
  // Configuration source
  // ****************************************
  always_comb begin
    pin_valid = 1'b1;
    case ({decay_pin_a, decay_pin_b})
      {pwm_chop_pkg::PIN_HIZ, pwm_chop_pkg::PIN_HIGH}: pin_decay = pwm_chop_pkg::DECAY_SLOW;
      {pwm_chop_pkg::PIN_HIGH, pwm_chop_pkg::PIN_LOW}: pin_decay = pwm_chop_pkg::DECAY_MIX30;
      {pwm_chop_pkg::PIN_HIZ, pwm_chop_pkg::PIN_LOW}:  pin_decay = pwm_chop_pkg::DECAY_MIX60;
      {pwm_chop_pkg::PIN_LOW, pwm_chop_pkg::PIN_LOW}:  pin_decay = pwm_chop_pkg::DECAY_DYN;
      {pwm_chop_pkg::PIN_LOW, pwm_chop_pkg::PIN_HIGH}: pin_decay = pwm_chop_pkg::DECAY_RIPPLE;
      default: begin
        pin_decay = pwm_chop_pkg::DECAY_RIPPLE;
        pin_valid = 1'b0;
      end
    endcase
  end

  // Scheme follows its source every cycle except on an invalid pin pair, so a change takes effect on the fly.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eff_decay_q <= pwm_chop_pkg::DECAY_RST;
    end else if (!hw_mode) begin
      eff_decay_q <= decay_q;
    end else if (pin_valid) begin
      eff_decay_q <= pin_decay;
    end
  end

  logic [1:0]  off_time_select_sel;
  logic [1:0]  ripple_sel;
  logic [12:0] off_cyc;
  logic [12:0] blank_cyc;
  logic [2:0]  ripple_pct;
  logic [11:0] vref_mv;
  logic [7:0]  scaler;
  logic [19:0] ref_prod;
  logic [14:0] ripple_prod;
  logic [11:0] ripple_sub;

  assign off_time_select_sel   = hw_mode ? off_time_pin : off_time_select_q;
  assign ripple_sel = hw_mode ? off_time_pin : ripple_q;

  always_comb begin
    case (off_time_select_sel)
      2'h0:    off_cyc = 13'(OFF0_CYC);
      2'h1:    off_cyc = 13'(OFF1_CYC);
      2'h2:    off_cyc = 13'(OFF2_CYC);
      default: off_cyc = 13'(OFF3_CYC);
    endcase
    case (hw_mode ? 2'h1 : blank_q)
      2'h0:    blank_cyc = 13'(pwm_chop_pkg::BLANK0_CYC);
      2'h1:    blank_cyc = 13'(pwm_chop_pkg::BLANK1_CYC);
      2'h2:    blank_cyc = 13'(pwm_chop_pkg::BLANK2_CYC);
      default: blank_cyc = 13'(pwm_chop_pkg::BLANK3_CYC);
    endcase
    case (ripple_sel)
      2'h0:    ripple_pct = pwm_chop_pkg::RIPPLE_PCT0;
      2'h1:    ripple_pct = pwm_chop_pkg::RIPPLE_PCT1;
      2'h2:    ripple_pct = pwm_chop_pkg::RIPPLE_PCT2;
      default: ripple_pct = pwm_chop_pkg::RIPPLE_PCT3;
    endcase
  end

  // ****************************************
  // Reference levels
  // ****************************************
  // Pin configuration has no scaler registers, so it runs at full scale.
  assign vref_mv     = (!hw_mode && vref_int_q) ? pwm_chop_pkg::VREF_INT_MV : ext_vref_mv;
  assign scaler      = hw_mode ? 8'hFF : (holding ? standstill_q : torque_q);
  assign ref_prod    = vref_mv * scaler;
  assign ripple_prod = trip_level * ripple_pct;
  assign ripple_sub  = RIPPLE_BASE + 12'(ripple_prod / 15'h064);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_level   <= 12'h000;
      valley_level <= 12'h000;
    end else begin
      trip_level   <= ref_prod[19:8];
      valley_level <= (trip_level > ripple_sub) ? trip_level - ripple_sub : 12'h000;
    end
  end

  // ****************************************
  // Chopping machines, one per bridge
  // ****************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  localparam int DEG_CYC = pwm_chop_pkg::DEGLITCH_CYC;

  a_reserved_keep: assert property (wr_pend_q && addr_q == pwm_chop_pkg::ADDR_CTRL
    && !decay_ok(hwdata[2:0]) |=> decay_q == $past(decay_q))
    else $error("reserved decay code changed the scheme");

  for (genvar b = 0; b < 2; b++) begin : g_bridge
    logic [12:0] tmr_q;
    logic [6:0]  deg_q;
    logic        fall_q;
    logic        trip_hit;
    logic        ripple;
    logic [12:0] fast_len;
    logic [16:0] frac_prod;

    assign ripple   = eff_decay_q == pwm_chop_pkg::DECAY_RIPPLE;
    assign trip_hit = sense[b].trip && deg_q >= 7'(DEG_CYC - 1);

    always_comb begin
      frac_prod = 17'h00000;
      case (eff_decay_q)
        pwm_chop_pkg::DECAY_MIX30: frac_prod = (17'(off_cyc) * 17'h00003) / 17'h0000A;
        pwm_chop_pkg::DECAY_MIX60: frac_prod = (17'(off_cyc) * 17'h00006) / 17'h0000A;
        pwm_chop_pkg::DECAY_DYN:   frac_prod = fall_q ? 17'(off_cyc)
                                             : (17'(off_cyc) * 17'(frac_q[b])) >> 3;
        default:                   frac_prod = 17'h00000;
      endcase
      fast_len = frac_prod[12:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        deg_q <= 7'h00;
      end else if (!sense[b].trip) begin
        deg_q <= 7'h00;
      end else if (deg_q != 7'h7F) begin
        deg_q <= deg_q + 7'h01;
      end
    end

    // Falling step request holds until the fast phase it forces has run.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        fall_q <= 1'b0;
      end else if (sense[b].falling_step) begin
        fall_q <= 1'b1;
      end else if (eff_decay_q != pwm_chop_pkg::DECAY_DYN) begin
        fall_q <= 1'b0;
      end else if (st_q[b] != pwm_chop_pkg::ST_DRIVE && st_q[b] != pwm_chop_pkg::ST_SLOW
                   && tmr_q + 13'h0001 >= fast_len) begin
        fall_q <= 1'b0;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        frac_q[b] <= pwm_chop_pkg::FRAC_RST;
      end else if (st_q[b] == pwm_chop_pkg::ST_DRIVE && tmr_q >= blank_cyc && trip_hit
                   && eff_decay_q == pwm_chop_pkg::DECAY_DYN) begin
        if (tmr_q == blank_cyc && frac_q[b] != pwm_chop_pkg::FRAC_MAX) begin
          frac_q[b] <= frac_q[b] + 4'h1;
        end else if (tmr_q >= 13'(LONG_DRIVE_CYC) && frac_q[b] != 4'h0) begin
          frac_q[b] <= frac_q[b] - 4'h1;
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        st_q[b] <= pwm_chop_pkg::ST_DRIVE;
        tmr_q   <= 13'h0000;
      end else begin
        case (st_q[b])
          pwm_chop_pkg::ST_DRIVE: begin
            if (tmr_q >= blank_cyc && trip_hit) begin
              st_q[b] <= (ripple || fast_len == 13'h0000) ? pwm_chop_pkg::ST_SLOW
                                                          : pwm_chop_pkg::ST_FAST;
              tmr_q   <= 13'h0000;
            end else if (tmr_q != 13'h1FFF) begin
              tmr_q <= tmr_q + 13'h0001;
            end
          end
          pwm_chop_pkg::ST_FAST, pwm_chop_pkg::ST_FAST_OFF: begin
            tmr_q <= tmr_q + 13'h0001;
            if (tmr_q + 13'h0001 >= fast_len) begin
              st_q[b] <= pwm_chop_pkg::ST_SLOW;
            end else if (sense[b].near_zero) begin
              st_q[b] <= pwm_chop_pkg::ST_FAST_OFF;
            end
          end
          pwm_chop_pkg::ST_SLOW: begin
            tmr_q <= tmr_q + 13'h0001;
            if (ripple) begin
              if (sense[b].valley) begin
                st_q[b] <= pwm_chop_pkg::ST_DRIVE;
                tmr_q   <= 13'h0000;
              end
            end else if (tmr_q + 13'h0001 >= off_cyc) begin
              tmr_q <= 13'h0000;
              if (!sense[b].trip) begin
                st_q[b] <= pwm_chop_pkg::ST_DRIVE;
              end
            end
          end
          default: begin
            st_q[b] <= pwm_chop_pkg::ST_DRIVE;
            tmr_q   <= 13'h0000;
          end
        endcase
      end
    end

    // Gates follow the state one cycle late; the analog drivers add their own dead time.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        gate[b] <= '0;
      end else begin
        case (st_q[b])
          pwm_chop_pkg::ST_DRIVE: gate[b] <= dir[b] ? 4'b1001 : 4'b0110;
          pwm_chop_pkg::ST_FAST:  gate[b] <= dir[b] ? 4'b0110 : 4'b1001;
          pwm_chop_pkg::ST_SLOW:  gate[b] <= 4'b0101;
          default:                gate[b] <= 4'b0000;
        endcase
      end
    end

    a_drive_hold: assert property (st_q[b] == pwm_chop_pkg::ST_DRIVE
      && !sense[b].trip |=> st_q[b] == pwm_chop_pkg::ST_DRIVE)
      else $error("drive left without trip");
    a_blank_ignore: assert property (st_q[b] == pwm_chop_pkg::ST_DRIVE
      && tmr_q < blank_cyc |=> st_q[b] == pwm_chop_pkg::ST_DRIVE)
      else $error("trip acted inside blanking");
    a_deglitch_wait: assert property (st_q[b] == pwm_chop_pkg::ST_DRIVE
      && deg_q < 7'(DEG_CYC - 1) |=> st_q[b] == pwm_chop_pkg::ST_DRIVE)
      else $error("trip acted before deglitch");
    a_fast_cutoff: assert property (st_q[b] == pwm_chop_pkg::ST_FAST && sense[b].near_zero
      && tmr_q + 13'h0001 < fast_len |=> st_q[b] == pwm_chop_pkg::ST_FAST_OFF ##1 gate[b] == 4'b0000)
      else $error("bridge not disabled near zero");
    a_slow_gates: assert property (st_q[b] == pwm_chop_pkg::ST_SLOW
      |=> gate[b] == 4'b0101)
      else $error("slow decay gates wrong");
    a_slow_extend: assert property (st_q[b] == pwm_chop_pkg::ST_SLOW && !ripple
      && tmr_q + 13'h0001 >= off_cyc && sense[b].trip
      |=> st_q[b] == pwm_chop_pkg::ST_SLOW && tmr_q == 13'h0000)
      else $error("slow decay not extended");
    a_off_resume: assert property (st_q[b] == pwm_chop_pkg::ST_SLOW && !ripple
      && tmr_q + 13'h0001 >= off_cyc && !sense[b].trip |=> st_q[b] == pwm_chop_pkg::ST_DRIVE)
      else $error("drive not resumed after off time");
    a_valley_wait: assert property (st_q[b] == pwm_chop_pkg::ST_SLOW && ripple
      && !sense[b].valley |=> st_q[b] == pwm_chop_pkg::ST_SLOW)
      else $error("ripple slow decay ended above valley");
    a_dyn_raise: assert property (st_q[b] == pwm_chop_pkg::ST_DRIVE && trip_hit
      && eff_decay_q == pwm_chop_pkg::DECAY_DYN && tmr_q == blank_cyc
      && frac_q[b] != pwm_chop_pkg::FRAC_MAX |=> frac_q[b] == $past(frac_q[b]) + 4'h1)
      else $error("overshoot did not raise fast fraction");

    c_fast_off: cover property (st_q[b] == pwm_chop_pkg::ST_FAST
      ##1 st_q[b] == pwm_chop_pkg::ST_FAST_OFF);
    c_slow_extend: cover property (st_q[b] == pwm_chop_pkg::ST_SLOW && !ripple
      && tmr_q + 13'h0001 >= off_cyc && sense[b].trip);
    c_valley_return: cover property (st_q[b] == pwm_chop_pkg::ST_SLOW && ripple
      ##1 st_q[b] == pwm_chop_pkg::ST_DRIVE);
  end

endmodule

/* tb/motor_model.sv */
// Behavioural model of both motor windings and their sense comparators.
// Assumes the chopper's gate patterns; current is in arbitrary units.
module motor_model #(
  parameter int TRIP   = 400,
  parameter int VALLEY = 360
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic [1:0]                   dir,
  input  wire pwm_chop_pkg::gate_type [1:0] gate,
  input  wire logic                         stall,
  input  wire logic                         fstep,
  output pwm_chop_pkg::sense_type [1:0]     sense
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Winding current
  // ****************************************
  int cur [2];
  // Stall freezes current so trip stays up and off periods repeat
  always @(posedge hclk or negedge hresetn) begin
    for (int b = 0; b < 2; b++) begin
      if (!hresetn) begin
        cur[b] <= 0;
      end else if (!stall) begin
        if (gate[b] == {dir[b], !dir[b], !dir[b], dir[b]}) begin
          cur[b] <= cur[b] + 1;
        end else if (gate[b] == {!dir[b], dir[b], dir[b], !dir[b]}) begin
          cur[b] <= (cur[b] > 8) ? cur[b] - 8 : 0;
        end else if (gate[b].ls1 && gate[b].ls2) begin
          // Decay outpaces the shortest drive, so one off period ends each cycle
          cur[b] <= (cur[b] > 6) ? cur[b] - 6 : 0;
        end
      end
    end
  end
  // Flags leave synchronous to hclk, one set per bridge
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      sense[b] = {cur[b] >= TRIP, cur[b] <= VALLEY, cur[b] < 4, fstep};
    end
  end
endmodule

/* tb/tb.sv */
// Self-checking bench of the chopping controller over AHB-Lite.
// Assumes the motor model as far side and shortened off periods.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hw_mode = 0, holding = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, dir = 2'h1, pa = 0, pb = 0, otp = 0;
  logic [11:0] ext_vref_mv = 12'h400, trip_level, valley_level;
  logic hreadyout, hresp, stall = 0, fstep = 0;
  pwm_chop_pkg::sense_type [1:0] sense;
  pwm_chop_pkg::gate_type [1:0]  gate;
  int num_errors = 0, compares = 0, cyc = 0, n;
  int offc [4] = '{40, 60, 80, 100};
  int blk [4] = '{pwm_chop_pkg::BLANK0_CYC, pwm_chop_pkg::BLANK1_CYC,
                  pwm_chop_pkg::BLANK2_CYC, pwm_chop_pkg::BLANK3_CYC};
  pwm_chop_ctrl #(.OFF0_CYC(40), .OFF1_CYC(60), .OFF2_CYC(80), .OFF3_CYC(100)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hw_mode(hw_mode), .decay_pin_a(pa),
    .decay_pin_b(pb), .off_time_pin(otp), .holding(holding), .ext_vref_mv(ext_vref_mv),
    .dir(dir), .sense(sense), .gate(gate), .trip_level(trip_level),
    .valley_level(valley_level));
  motor_model model (.hclk(hclk), .hresetn(hresetn), .dir(dir), .gate(gate),
    .stall(stall), .fstep(fstep), .sense(sense));
  always #4 hclk = ~hclk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wctrl(input int d, input int t, input int b);
    ahb(1, pwm_chop_pkg::ADDR_CTRL, 32'h1000 | (b << 6) | (t << 4) | d);
  endtask
  // Counts one fresh run of a gate pattern on bridge 0, capped
  task automatic run_len(input logic [3:0] p, input int cap);
    n = 0;
    do @(negedge hclk); while (gate[0] === p);
    do @(negedge hclk); while (gate[0] !== p);
    while (gate[0] === p && n < cap) begin
      n++;
      @(negedge hclk);
    end
  endtask
  task automatic conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      conclude();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    repeat (2) @(negedge hclk);
    chk("gate0", 4'h9, gate[0]);
    chk("gate1", 4'h6, gate[1]);
    ahb(0, pwm_chop_pkg::ADDR_CTRL, 0);
    chk("ctrl", 32'h57, rd);
    chk("hresp", 0, hresp);
    ahb(0, pwm_chop_pkg::ADDR_SCALE, 0);
    chk("scale", 32'h80FF, rd);
    ahb(0, 8'h0C, 0);
    chk("unmapped", 0, rd);
    chk("trip ext", 12'h3FC, trip_level);
    wctrl(7, 0, 1);
    repeat (3) @(negedge hclk);
    chk("trip int", 12'hCD7, trip_level);
    holding <= 1;
    repeat (3) @(negedge hclk);
    chk("hold", 12'h672, trip_level);
    chk("valley", 12'h649, valley_level);
    holding <= 0;
    foreach (offc[i]) begin
      wctrl(i == 0 ? 0 : i + 3, 0, 1);
      ahb(0, pwm_chop_pkg::ADDR_STATUS, 0);
      chk("decay", i == 0 ? 0 : i + 3, rd[6:4]);
    end
    wctrl(2, 0, 1);
    ahb(0, pwm_chop_pkg::ADDR_STATUS, 0);
    chk("reserved", 3'h6, rd[6:4]);
    foreach (offc[t]) begin
      wctrl(0, t, 1);
      run_len(4'h5, 500);
      chk("off", offc[t], n);
    end
    wctrl(0, 0, 1);
    run_len(4'h5, 1);
    stall <= 1;
    // Count on in the run already under way; frozen current never lets it end
    n = 0;
    while (gate[0] === 4'h5 && n < 130) begin
      n++;
      @(negedge hclk);
    end
    chk("slow extend", 130, n);
    stall <= 0;
    for (int m = 4; m < 6; m++) begin
      wctrl(m, 0, 1);
      run_len(4'h6, 500);
      chk("fast part", m == 4 ? 12 : 24, n);
      run_len(4'h5, 500);
      chk("slow part", m == 4 ? 28 : 16, n);
    end
    wctrl(6, 0, 1);
    // Returns as a drive phase starts, so the forced fast phase is the next one
    run_len(4'h5, 500);
    fstep <= 1;
    @(posedge hclk);
    fstep <= 0;
    run_len(4'h6, 500);
    chk("full fast", 40, n);
    wctrl(7, 3, 1);
    run_len(4'h5, 500);
    run_len(4'h5, 500);
    chk("ripple valley", 1, n < 100);
    foreach (blk[b]) begin
      wctrl(0, 0, b);
      run_len(4'h9, 3000);
      chk("blank", 1, n >= blk[b]);
    end
    hw_mode <= 1;
    pa <= pwm_chop_pkg::PIN_LOW;
    pb <= pwm_chop_pkg::PIN_LOW;
    ahb(0, pwm_chop_pkg::ADDR_STATUS, 0);
    ahb(0, pwm_chop_pkg::ADDR_STATUS, 0);
    chk("pin decay", 3'h6, rd[6:4]);
    pa <= pwm_chop_pkg::PIN_HIGH;
    pb <= pwm_chop_pkg::PIN_HIGH;
    ahb(0, pwm_chop_pkg::ADDR_STATUS, 0);
    ahb(0, pwm_chop_pkg::ADDR_STATUS, 0);
    chk("pin reserved", 3'h6, rd[6:4]);
    conclude();
  end
endmodule
